// File: pfl_monitor.sv
/*
 Phase fault monitor: supply/reference reset filter, per-phase
 power, dropout and reverse detection, phase sequence check, and
 the multiplexed LED select and phase indicator pins.
 Assumes samples and comparator levels synchronous to i_ref_clk.
*/
// Functional notes
// - supply or reference low: outputs idle, datapath reset
// - both good: release datapath, enable outputs
// - either falls low: hold datapath reset again
// - supply decision filtered with asymmetric hysteresis
// - priority: dropout, sequence error, reverse power
// - any dropout suppresses sequence error indication
// - dropped phase still shows reverse power
// - select high: pin low lights dropout LED
// - select low: pin high lights reverse LED
// - select toggles continuously at fixed rate
// - dropout on low amplitude or crossing timeout
// - dropout LED lit about 150 ms after
// - energy keeps accumulating during dropout
// - clear dropout after crossings and amplitude return
// - crossing order must be A, B, C
// - sequence error blinks dropout LEDs at 1 Hz
// - reverse LED steady while sequence LEDs blink
// - blinking begins about 150 ms after violation
// - per-phase active power, total is the sum
// - reverse flag follows sign of low-pass filtered power
`timescale 1ns/10ps

module pfl_phase
    import pfl_pkg::*;
#(
    parameter int unsigned W = SAMPLE_W,
    parameter int unsigned AW = 2 * SAMPLE_W,
    parameter int unsigned CW = 24,
    parameter int unsigned DROP_N = DROP_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_valid,
    input wire logic signed [W-1:0] i_volt,
    input wire logic signed [W-1:0] i_curr,
    output logic o_xing,
    output logic o_drop,
    output logic o_rev,
    output logic signed [AW-1:0] o_power
);
    localparam logic [W-1:0] AMP_THR = W'(((2 ** (W - 1)) - 1) * AMP_PCT / 100);

    typedef struct packed {
        logic signed [W-1:0] prev;
        logic [W-1:0] peak;
        logic amp_ok;
        logic [CW-1:0] xtmr;
        logic [CW-1:0] pcnt;
        logic drop;
        logic xing;
        logic signed [AW-1:0] acc;
    } pfl_ph_t;

    pfl_ph_t st_reg;
    pfl_ph_t st_next;
    logic [W-1:0] mag;
    logic no_xing;
    logic good;
    logic signed [AW-1:0] prod;

    always_comb begin
        st_next = st_reg;
        mag = i_volt[W-1] ? W'(-i_volt) : W'(i_volt);
        prod = AW'(i_volt * i_curr);
        st_next.xing = 1'b0;
        if (i_valid) begin
            st_next.prev = i_volt;
            st_next.peak = (mag > st_reg.peak) ? mag : st_reg.peak;
            if (st_reg.prev[W-1] && !i_volt[W-1]) begin
                st_next.xing = 1'b1;
                st_next.amp_ok = (st_reg.peak >= AMP_THR);
                st_next.peak = mag;
            end
            st_next.acc = st_reg.acc + ((prod - st_reg.acc) >>> LPF_SHIFT);
        end
        if (st_next.xing) begin
            st_next.xtmr = '0;
        end else if (st_reg.xtmr != CW'(DROP_N)) begin
            st_next.xtmr = st_reg.xtmr + CW'(1);
        end
        no_xing = (st_reg.xtmr == CW'(DROP_N));
        good = !no_xing && st_reg.amp_ok;
        if (!st_reg.drop && no_xing) begin
            st_next.drop = 1'b1;
            st_next.pcnt = '0;
        end else if (st_reg.drop ? good : !st_reg.amp_ok) begin
            if (st_reg.pcnt == CW'(DROP_N)) begin
                st_next.drop = !st_reg.drop;
                st_next.pcnt = '0;
            end else begin
                st_next.pcnt = st_reg.pcnt + CW'(1);
            end
        end else begin
            st_next.pcnt = '0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            st_reg <= '{prev: '0, peak: '0, amp_ok: 1'b1, xtmr: '0,
                        pcnt: '0, drop: 1'b0, xing: 1'b0, acc: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_xing = st_reg.xing;
    assign o_drop = st_reg.drop;
    assign o_rev = st_reg.acc[AW-1];
    assign o_power = st_reg.acc;
endmodule // pfl_phase

module pfl_monitor
    import pfl_pkg::*;
#(
    parameter int unsigned W = SAMPLE_W,
    parameter int unsigned DROP_N = DROP_CYC,
    parameter int unsigned BLINK_N = BLINK_HALF,
    parameter int unsigned SEL_N = SEL_HALF,
    parameter int unsigned SUP_ON_N = SUP_ON_CYC,
    parameter int unsigned SUP_OFF_N = SUP_OFF_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_supply_ok,
    input wire logic i_ref_ok,
    input wire logic i_sample_valid,
    input wire logic signed [W-1:0] i_volt_a,
    input wire logic signed [W-1:0] i_volt_b,
    input wire logic signed [W-1:0] i_volt_c,
    input wire logic signed [W-1:0] i_curr_a,
    input wire logic signed [W-1:0] i_curr_b,
    input wire logic signed [W-1:0] i_curr_c,
    output logic o_datapath_reset,
    output logic o_indicator_select,
    output logic o_phase_a_indicator,
    output logic o_phase_b_indicator,
    output logic o_phase_c_indicator,
    output logic [PHASES-1:0] o_reverse_power_flag,
    output logic [PHASES-1:0] o_phase_dropout,
    output logic o_seq_error,
    output logic signed [2*W+1:0] o_total_power,
    output logic signed [ENERGY_W-1:0] o_energy
);
    localparam int unsigned AW = 2 * W;
    localparam int unsigned TW = AW + 2;
    localparam int unsigned CW = $clog2(BLINK_N + DROP_N + SUP_ON_N + SEL_N + 2);

    generate
        if (W < 4 || W > 24 || DROP_N < 1 || BLINK_N < 1 || SEL_N < 1
            || SUP_ON_N < 1 || SUP_OFF_N < 1) begin : g_bad
            $error("pfl_monitor: unsupported parameter value");
        end
    endgenerate

    typedef struct packed {
        logic dp_on;
        logic [CW-1:0] sup_cnt;
        logic [1:0] last;
        logic last_v;
        logic [1:0] ok_run;
        logic pend;
        logic [CW-1:0] pcnt;
        logic seq_err;
        logic blink;
        logic [CW-1:0] bcnt;
        logic sel;
        logic [CW-1:0] scnt;
        logic [PHASES-1:0] ind;
        logic [PHASES-1:0] rev;
        logic [PHASES-1:0] drop;
        logic signed [TW-1:0] total;
        logic signed [ENERGY_W-1:0] energy;
    } pfl_top_t;

    pfl_top_t st_reg;
    pfl_top_t st_next;
    logic ph_rst;
    logic [PHASES-1:0] xing;
    logic [PHASES-1:0] drop;
    logic [PHASES-1:0] rev;
    logic signed [AW-1:0] pwr [PHASES];
    logic signed [W-1:0] volt [PHASES];
    logic signed [W-1:0] curr [PHASES];
    logic [1:0] ph;
    logic [1:0] expect_ph;
    logic lit;

    assign volt[0] = i_volt_a;
    assign volt[1] = i_volt_b;
    assign volt[2] = i_volt_c;
    assign curr[0] = i_curr_a;
    assign curr[1] = i_curr_b;
    assign curr[2] = i_curr_c;
    // datapath held while filtered supply and reference not good
    assign ph_rst = i_rst || !st_reg.dp_on;

    generate
        for (genvar g = 0; g < PHASES; g++) begin : g_ph
            pfl_phase #(
                .W(W),
                .AW(AW),
                .CW(CW),
                .DROP_N(DROP_N)
            ) u_ph (
                .i_ref_clk(i_ref_clk),
                .i_rst(ph_rst),
                .i_valid(i_sample_valid),
                .i_volt(volt[g]),
                .i_curr(curr[g]),
                .o_xing(xing[g]),
                .o_drop(drop[g]),
                .o_rev(rev[g]),
                .o_power(pwr[g])
            );
        end
    endgenerate

    always_comb begin
        st_next = st_reg;
        ph = 2'd0;
        lit = 1'b0;
        if (st_reg.dp_on == (i_supply_ok && i_ref_ok)) begin
            st_next.sup_cnt = '0;
        end else if (st_reg.sup_cnt
                     == CW'(st_reg.dp_on ? SUP_OFF_N - 1 : SUP_ON_N - 1)) begin
            st_next.dp_on = !st_reg.dp_on;
            st_next.sup_cnt = '0;
        end else begin
            st_next.sup_cnt = st_reg.sup_cnt + CW'(1);
        end

        // total is the sum of phases
        st_next.total = TW'(pwr[0]) + TW'(pwr[1]) + TW'(pwr[2]);
        st_next.energy = st_reg.energy + ENERGY_W'(st_reg.total);

        if (st_reg.scnt == CW'(SEL_N - 1)) begin
            st_next.scnt = '0;
            st_next.sel = !st_reg.sel;
        end else begin
            st_next.scnt = st_reg.scnt + CW'(1);
        end
        if (st_reg.bcnt == CW'(BLINK_N - 1)) begin
            st_next.bcnt = '0;
            st_next.blink = !st_reg.blink;
        end else begin
            st_next.bcnt = st_reg.bcnt + CW'(1);
        end

        for (int i = PHASES - 1; i >= 0; i--) begin
            if (xing[i]) begin
                ph = 2'(i);
            end
        end
        expect_ph = (st_reg.last == 2'd2) ? 2'd0 : st_reg.last + 2'd1;

        if (|drop) begin
            st_next.last_v = 1'b0;
            st_next.ok_run = 2'd0;
            st_next.pend = 1'b0;
            st_next.seq_err = 1'b0;
        end else begin
            if (|xing) begin
                st_next.last = ph;
                st_next.last_v = 1'b1;
                if (st_reg.last_v && ph != expect_ph) begin
                    st_next.ok_run = 2'd0;
                    if (!st_reg.seq_err) begin
                        st_next.pend = 1'b1;
                    end
                end else if (st_reg.ok_run == 2'd2) begin
                    st_next.ok_run = 2'd0;
                    st_next.pend = 1'b0;
                    st_next.seq_err = 1'b0;
                end else begin
                    st_next.ok_run = st_reg.ok_run + 2'd1;
                end
            end
            if (st_reg.pend && st_next.pend) begin
                if (st_reg.pcnt == CW'(DROP_N)) begin
                    st_next.pend = 1'b0;
                    st_next.seq_err = 1'b1;
                end else begin
                    st_next.pcnt = st_reg.pcnt + CW'(1);
                end
            end else begin
                st_next.pcnt = '0;
            end
        end

        st_next.drop = drop;
        st_next.rev = rev;
        for (int i = 0; i < PHASES; i++) begin
            lit = drop[i] || (st_reg.seq_err && st_reg.blink);
            if (st_next.sel) begin
                st_next.ind[i] = !lit;
            end else begin
                st_next.ind[i] = rev[i];
            end
        end

        if (!st_reg.dp_on) begin
            st_next.last_v = 1'b0;
            st_next.ok_run = 2'd0;
            st_next.pend = 1'b0;
            st_next.pcnt = '0;
            st_next.seq_err = 1'b0;
            st_next.blink = 1'b0;
            st_next.bcnt = '0;
            st_next.sel = 1'b0;
            st_next.scnt = '0;
            st_next.ind = '0;
            st_next.rev = '0;
            st_next.drop = '0;
            st_next.total = '0;
            st_next.energy = '0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_datapath_reset = !st_reg.dp_on;
    assign o_indicator_select = st_reg.sel;
    assign o_phase_a_indicator = st_reg.ind[0];
    assign o_phase_b_indicator = st_reg.ind[1];
    assign o_phase_c_indicator = st_reg.ind[2];
    assign o_reverse_power_flag = st_reg.rev;
    assign o_phase_dropout = st_reg.drop;
    assign o_seq_error = st_reg.seq_err;
    assign o_total_power = st_reg.total;
    assign o_energy = st_reg.energy;
endmodule // pfl_monitor

// File: pfl_pkg.sv
/*
 Constants for the phase fault LED monitor: clock rate, timing
 figures and the cycle counts derived from them.
 Assumes a single 100 MHz reference clock.
*/
package pfl_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    // dropout and sequence persistence window
    localparam int unsigned DROP_TIME_MS = 150;
    localparam int unsigned DROP_CYC = CLK_HZ / 1000 * DROP_TIME_MS;
    // sequence error blink rate
    localparam int unsigned BLINK_HZ = 1;
    localparam int unsigned BLINK_HALF = CLK_HZ / (2 * BLINK_HZ);
    // indicator select rate, half period count rounded down
    localparam int unsigned SEL_HZ = 131_000;
    localparam int unsigned SEL_HALF = CLK_HZ / (2 * SEL_HZ);
    // supply monitor filter: slow release, faster assertion
    localparam int unsigned SUP_ON_US = 10;
    localparam int unsigned SUP_OFF_US = 2;
    localparam int unsigned SUP_ON_CYC = CLK_HZ / 1_000_000 * SUP_ON_US;
    localparam int unsigned SUP_OFF_CYC = CLK_HZ / 1_000_000 * SUP_OFF_US;
    // amplitude dropout level, percent of full scale
    localparam int unsigned AMP_PCT = 20;
    localparam int unsigned SAMPLE_W = 16;
    localparam int unsigned LPF_SHIFT = 8;
    localparam int unsigned ENERGY_W = 48;
    localparam int unsigned PHASES = 3;
endpackage

// File: pfl_chk.sv
/*
 Checker for the phase fault monitor top ports.
 Assumes bind from tb with SEL_N 4, SUP_ON_N 8, SUP_OFF_N 3.
*/
`timescale 1ns/10ps
module pfl_chk
    import pfl_pkg::*;
#(
    parameter int unsigned W = SAMPLE_W
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_supply_ok,
    input wire logic i_ref_ok,
    input wire logic o_datapath_reset,
    input wire logic o_indicator_select,
    input wire logic o_phase_a_indicator,
    input wire logic o_phase_b_indicator,
    input wire logic [PHASES-1:0] o_reverse_power_flag,
    input wire logic [PHASES-1:0] o_phase_dropout,
    input wire logic o_seq_error,
    input wire logic signed [2*W+1:0] o_total_power,
    input wire logic signed [ENERGY_W-1:0] o_energy
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    sequence s_bad;
        !(i_supply_ok && i_ref_ok) [*3];
    endsequence
    sequence s_sel_hold;
        $stable(o_indicator_select) [*3] ##1 $changed(o_indicator_select);
    endsequence
    property p_idle;
        o_datapath_reset && $past(o_datapath_reset) |-> !o_indicator_select
            && !o_phase_a_indicator && !o_phase_b_indicator && !o_seq_error
            && o_reverse_power_flag == 3'h0 && o_phase_dropout == 3'h0;
    endproperty
    property p_down;
        s_bad |-> ##[1:3] o_datapath_reset;
    endproperty
    property p_up;
        $fell(o_datapath_reset) |->
            $past(i_supply_ok && i_ref_ok, 2) && $past(i_supply_ok && i_ref_ok, 7);
    endproperty
    property p_sel_hi;
        o_indicator_select && o_phase_dropout[0] && $past(o_phase_dropout[0])
            |-> !o_phase_a_indicator;
    endproperty
    property p_sel_lo;
        !o_indicator_select && $stable(o_reverse_power_flag[1])
            |-> o_phase_b_indicator == o_reverse_power_flag[1];
    endproperty
    property p_sel_rate;
        disable iff (i_rst || o_datapath_reset)
        $changed(o_indicator_select) |=> s_sel_hold;
    endproperty
    property p_seq_sup;
        (|o_phase_dropout) && $past(|o_phase_dropout) |-> !o_seq_error;
    endproperty
    property p_energy;
        !o_datapath_reset && !$past(o_datapath_reset)
            |-> o_energy == $past(o_energy) + $past(o_total_power);
    endproperty
    a_idle: assert property (p_idle) else $error("outputs active in reset");
    a_down: assert property (p_down) else $error("no reset on bad supply");
    a_up: assert property (p_up) else $error("early datapath release");
    a_sel_hi: assert property (p_sel_hi) else $error("dropout led off");
    a_sel_lo: assert property (p_sel_lo) else $error("reverse led wrong");
    a_sel_rate: assert property (p_sel_rate) else $error("select rate wrong");
    a_seq_sup: assert property (p_seq_sup) else $error("sequence error in dropout");
    a_energy: assert property (p_energy) else $error("energy sum wrong");
endmodule // pfl_chk

// File: pfl_leds.sv
/*
 LED pairs on the multiplexed phase pins.
 Assumes pins and select change together on the clock.
*/
`timescale 1ns/10ps
module pfl_leds (
    input wire logic i_ref_clk,
    input wire logic i_sel,
    input wire logic [2:0] i_pin,
    output logic [2:0] o_drop_lit,
    output logic [2:0] o_rev_lit
);
    always_ff @(posedge i_ref_clk) begin
        if (i_sel) begin
            o_drop_lit <= ~i_pin;
        end else begin
            o_rev_lit <= i_pin;
        end
    end
endmodule // pfl_leds

// File: tb.sv
/*
 Testbench for the phase fault monitor with square phase waves.
 Assumes shortened counts on the top module.
*/
`timescale 1ns/10ps
module tb;
    import pfl_pkg::*;
    typedef struct {int id; logic [7:0] e;} pfl_note_t;
    logic i_ref_clk = 0, i_rst = 1, sup = 0, rok = 0, sv = 0;
    logic signed [15:0] v [3] = '{0, 0, 0};
    logic signed [15:0] c [3] = '{0, 0, 0};
    logic dpr, sel, pa, pb, pc, seq;
    logic [2:0] rev, drop, dlit, rlit, blk;
    logic signed [33:0] tp;
    logic signed [47:0] en;
    int off [3] = '{0, 40, 20};
    int amp [3] = '{30000, 30000, 30000};
    int csg [3] = '{1, 1, 1};
    bit frz [3] = '{0, 0, 0};
    int t = 0, cmag = 4000, n_errors = 0, n_checks = 0;
    pfl_note_t q [$];
    pfl_note_t n;
    string nm [8] = '{"dp_reset", "rev", "drop", "seq", "drop_led", "rev_led", "pwr", "blink"};
    pfl_monitor #(.DROP_N(200), .BLINK_N(50), .SEL_N(4), .SUP_ON_N(8), .SUP_OFF_N(3)) i_dut (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_supply_ok(sup), .i_ref_ok(rok),
        .i_sample_valid(sv), .i_volt_a(v[0]), .i_volt_b(v[1]), .i_volt_c(v[2]),
        .i_curr_a(c[0]), .i_curr_b(c[1]), .i_curr_c(c[2]), .o_datapath_reset(dpr),
        .o_indicator_select(sel), .o_phase_a_indicator(pa), .o_phase_b_indicator(pb),
        .o_phase_c_indicator(pc), .o_reverse_power_flag(rev), .o_phase_dropout(drop),
        .o_seq_error(seq), .o_total_power(tp), .o_energy(en));
    pfl_leds i_leds (.i_ref_clk(i_ref_clk), .i_sel(sel), .i_pin({pc, pb, pa}),
        .o_drop_lit(dlit), .o_rev_lit(rlit));
    initial begin
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    always @(posedge i_ref_clk) begin
        int vv;
        t <= t + 1;
        sv <= ($urandom_range(0, 3) != 0);
        for (int k = 0; k < 3; k++) begin
            vv = (frz[k] || (t + off[k]) % 60 >= 30) ? amp[k] : -amp[k];
            v[k] <= 16'(vv);
            c[k] <= 16'(vv > 0 ? csg[k] * cmag : -csg[k] * cmag);
        end
    end
    function automatic logic [7:0] obs(input int id);
        case (id)
            0: return {7'h0, dpr};
            1: return {5'h0, rev};
            2: return {5'h0, drop};
            3: return {7'h0, seq};
            4: return {5'h0, dlit};
            5: return {5'h0, rlit};
            6: return {7'h0, tp > 0};
            default: return {5'h0, blk};
        endcase
    endfunction
    task automatic note(input int id, input logic [7:0] e);
        q.push_back('{id, e});
    endtask
    task automatic cmp(input int id, input logic [7:0] e, input logic [7:0] s);
        n_checks++;
        if (s !== e) begin
            n_errors++;
            $display("BAD %s exp %h seen %h", nm[id], e, s);
        end
    endtask
    always @(negedge i_ref_clk) begin
        while (q.size() > 0) begin
            n = q.pop_front();
            cmp(n.id, n.e, obs(n.id));
        end
    end
    task automatic wc(input int k);
        repeat (k) @(posedge i_ref_clk);
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        wc(10000);
        n_errors++;
        close_out();
    end
    initial begin
        void'($urandom(1534));
        cmag = $urandom_range(1000, 8000);
        wc(16);
        i_rst <= 0; sup <= 1; rok <= 1;
        wc(5); rok <= 0; wc(1); rok <= 1;
        wc(6); note(0, 1);
        wc(10); note(0, 0);
        wc(600); note(2, 0); note(3, 0); note(4, 0); note(5, 0); note(6, 1);
        csg[1] <= -1; wc(400); note(1, 3'h2); note(5, 3'h2);
        frz[1] <= 1; wc(130); note(2, 0);
        wc(130); note(2, 3'h2); note(4, 3'h2);
        note(3, 0); note(5, 3'h2);
        frz[1] <= 0; wc(150); note(2, 3'h2); wc(200); note(2, 0);
        amp[0] <= 1000; wc(400); note(2, 3'h1); note(4, 3'h1);
        amp[0] <= 30000; wc(400); note(2, 0);
        off <= '{0, 20, 40}; wc(100); note(3, 0);
        wc(300); note(3, 1); note(2, 0);
        blk = 3'h0;
        for (int i = 0; i < 150; i++) begin
            @(negedge i_ref_clk);
            blk |= {rlit !== 3'h2, dlit === 3'h7, dlit === 3'h0};
        end
        wc(1); note(7, 3'h3);
        sup <= 0; wc(2); sup <= 1; wc(5); note(0, 0);
        rok <= 0; wc(10); note(0, 1); note(1, 0); note(3, 0);
        wc(2);
        close_out();
    end
endmodule // tb
bind pfl_monitor pfl_chk #(.W(W)) i_chk (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_supply_ok(i_supply_ok), .i_ref_ok(i_ref_ok),
    .o_datapath_reset(o_datapath_reset), .o_indicator_select(o_indicator_select),
    .o_phase_a_indicator(o_phase_a_indicator), .o_phase_b_indicator(o_phase_b_indicator),
    .o_reverse_power_flag(o_reverse_power_flag), .o_phase_dropout(o_phase_dropout),
    .o_seq_error(o_seq_error), .o_total_power(o_total_power), .o_energy(o_energy));
